// file: core/temp_limit_pkg.sv
// Package: register map, field layout and carrier types of the limit/status bank
package temp_limit_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] ADDR_CRIT_LOW_THRESH_HI = 8'h23;
    localparam logic [7:0] ADDR_DEVICE_EVENT_STATUS = 8'h30;
    localparam logic [7:0] ADDR_SENSED_TEMP_LO = 8'h31;
    localparam logic [7:0] ADDR_SENSED_TEMP_HI = 8'h32;
    localparam logic [7:0] ADDR_THRESHOLD_COMPARE_STATUS = 8'h33;
    localparam logic [7:0] ADDR_BUS_ERROR_STATUS = 8'h34;

    // ****************************************************************
    // Reset values and field layout
    // ****************************************************************
    localparam logic [7:0] RST_CRIT_LOW_THRESH_HI = 8'h00;
    localparam logic [7:0] RST_SENSED_TEMP = 8'h00;
    localparam logic [7:0] RST_STATUS = 8'h00;
    // Bits 7:5 of the threshold upper byte are read-zero
    localparam logic [7:0] CRIT_LOW_HI_WMASK = 8'h1f;
    localparam int INBAND_IRQ_BIT = 7;
    localparam int CRIT_FLOOR_BIT = 3;
    localparam int CRIT_CEILING_BIT = 2;
    localparam int FLOOR_BIT = 1;
    localparam int CEILING_BIT = 0;
    localparam int PACKET_CHECK_BIT = 1;
    localparam int WRITE_PARITY_BIT = 0;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    typedef struct packed {
        logic [15:0] high;
        logic [15:0] low;
        logic [15:0] critHigh;
        logic [7:0] critLowLo;
    } thresholds_t;

    typedef struct packed {
        logic [7:0] addr;
        logic write;
        logic read;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] rdata;
    } reg_rsp_t;

endpackage

// file: core/temp_limit_status_regs.sv
// Module: critical-low threshold, sensed reading, compare and error status registers
`timescale 1ns/1ps

// Function
// R1: Critical-low flag set when reading below floor
// R2: Critical-low threshold 16 bits, upper byte 23h
// R3: Read-zero threshold bits ignore writes, read zero
// R4: Host keeps critical-low below ordinary low
// R5: Bit 7 at 30h shows pending in-band interrupt
// R6: 31h returns low byte of latest reading
// R7: 32h returns high byte of latest reading
// R8: 33h holds compare outcome against four thresholds
// R9: Bit 2 set above critical-high threshold
// R10: Bit 1 set below ordinary low threshold
// R11: Bit 0 set above ordinary high threshold
// R12: Packet-check failure sets bit 1 at 34h (here only while pecEnable is high)
// R13: Write parity failure sets bit 0 in I3C
// R14: Compare all values as 16-bit, per conversion
// R15: Error flags sticky until external clear, reset zero
module temp_limit_status_regs (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Register port from the protocol engine
    input wire temp_limit_pkg::reg_req_t regReq,
    output temp_limit_pkg::reg_rsp_t regRsp,
    // Operating mode
    input wire logic i3cMode,
    input wire logic pecEnable,
    // Converter result
    input wire logic convDone,
    input wire logic [15:0] convResult,
    // Companion threshold registers held elsewhere, and the full critical-low threshold out
    input wire temp_limit_pkg::thresholds_t thresholds,
    output logic [15:0] critLowThresh,
    // Bus events and flag clearing
    input wire logic inbandIrqPending,
    input wire logic packetCheckFail,
    input wire logic writeParityFail,
    input wire logic errorClear,
    // Compare flags for the alert logic
    output logic [3:0] compareFlags
);

    // ****************************************************************
    // State
    // ****************************************************************
    logic [7:0] critFloorUpperByte_q;
    logic [15:0] reading_q;
    logic critFloorFlag_q;
    logic critCeilingFlag_q;
    logic floorFlag_q;
    logic ceilingFlag_q;
    logic packetCheckFailFlag_q;
    logic writeParityFailFlag_q;
    logic [7:0] readData_d;
    logic [15:0] critFloorFull;
    logic floorWrite;
    logic signed [15:0] resultSigned;
    logic signed [15:0] critFloorSigned;
    logic signed [15:0] critCeilingSigned;
    logic signed [15:0] floorSigned;
    logic signed [15:0] ceilingSigned;

    // The companion low byte lives outside; this block owns the upper byte
    assign critFloorFull = {critFloorUpperByte_q, thresholds.critLowLo}; // see R2

    // ****************************************************************
    // Decode and compare operands
    // ****************************************************************
    // Only the upper byte of the critical floor is writable in this bank
    assign floorWrite = regReq.write
        && (regReq.addr == temp_limit_pkg::ADDR_CRIT_LOW_THRESH_HI);

    // Two's-complement views keep every compare below in one encoding
    assign resultSigned = $signed(convResult); // see R14
    assign critFloorSigned = $signed(critFloorFull);
    assign critCeilingSigned = $signed(thresholds.critHigh);
    assign floorSigned = $signed(thresholds.low);
    assign ceilingSigned = $signed(thresholds.high);

    // ****************************************************************
    // Threshold upper byte
    // ****************************************************************
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            critFloorUpperByte_q <= temp_limit_pkg::RST_CRIT_LOW_THRESH_HI;
        end else if (floorWrite) begin
            // Ones written to read-zero bits are dropped here
            critFloorUpperByte_q <= regReq.wdata & temp_limit_pkg::CRIT_LOW_HI_WMASK; // see R3
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            critLowThresh <= {temp_limit_pkg::RST_CRIT_LOW_THRESH_HI, 8'h00};
        end else begin
            critLowThresh <= critFloorFull; // see R2
        end
    end

    // ****************************************************************
    // Latest reading
    // ****************************************************************
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            reading_q <= {temp_limit_pkg::RST_SENSED_TEMP, temp_limit_pkg::RST_SENSED_TEMP};
        end else if (convDone) begin
            reading_q <= convResult; // see R6, R7
        end
    end

    // ****************************************************************
    // Threshold compare
    // ****************************************************************
    // Compared signed: readings below zero must not look like huge values.
    // Equality with a threshold leaves the flag clear. Ordering of the
    // thresholds is left to the host; no cross-check is made here.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            critFloorFlag_q <= 1'b0;
        end else if (convDone) begin
            critFloorFlag_q <= resultSigned < critFloorSigned; // see R1, R4, R8, R14
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            critCeilingFlag_q <= 1'b0;
        end else if (convDone) begin
            critCeilingFlag_q <= resultSigned > critCeilingSigned; // see R9
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            floorFlag_q <= 1'b0;
        end else if (convDone) begin
            floorFlag_q <= resultSigned < floorSigned; // see R10
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ceilingFlag_q <= 1'b0;
        end else if (convDone) begin
            ceilingFlag_q <= resultSigned > ceilingSigned; // see R11
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            compareFlags <= temp_limit_pkg::RST_STATUS[3:0];
        end else begin
            compareFlags[temp_limit_pkg::CRIT_FLOOR_BIT] <= critFloorFlag_q; // see R1
            compareFlags[temp_limit_pkg::CRIT_CEILING_BIT] <= critCeilingFlag_q; // see R9
            compareFlags[temp_limit_pkg::FLOOR_BIT] <= floorFlag_q; // see R10
            compareFlags[temp_limit_pkg::CEILING_BIT] <= ceilingFlag_q; // see R11
        end
    end

    // ****************************************************************
    // Sticky error flags
    // ****************************************************************
    // A failure in the same cycle as the clear survives the clear
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            packetCheckFailFlag_q <= 1'b0;
        end else if (pecEnable && packetCheckFail) begin
            packetCheckFailFlag_q <= 1'b1; // see R12, R15
        end else if (errorClear) begin
            packetCheckFailFlag_q <= 1'b0; // see R15
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            writeParityFailFlag_q <= 1'b0;
        end else if (i3cMode && writeParityFail) begin
            writeParityFailFlag_q <= 1'b1; // see R13, R15
        end else if (errorClear) begin
            writeParityFailFlag_q <= 1'b0; // see R15
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    always_comb begin
        readData_d = 8'h00;
        case (regReq.addr)
            temp_limit_pkg::ADDR_CRIT_LOW_THRESH_HI: begin
                readData_d = critFloorUpperByte_q & temp_limit_pkg::CRIT_LOW_HI_WMASK; // see R3
            end
            temp_limit_pkg::ADDR_DEVICE_EVENT_STATUS: begin
                // Only meaningful on I3C; reserved bits stay zero
                readData_d[temp_limit_pkg::INBAND_IRQ_BIT] = i3cMode && inbandIrqPending; // see R5
            end
            temp_limit_pkg::ADDR_SENSED_TEMP_LO: begin
                readData_d = reading_q[7:0]; // see R6
            end
            temp_limit_pkg::ADDR_SENSED_TEMP_HI: begin
                readData_d = reading_q[15:8]; // see R7
            end
            temp_limit_pkg::ADDR_THRESHOLD_COMPARE_STATUS: begin
                // see R8
                readData_d[temp_limit_pkg::CRIT_FLOOR_BIT] = critFloorFlag_q; // see R1
                readData_d[temp_limit_pkg::CRIT_CEILING_BIT] = critCeilingFlag_q; // see R9
                readData_d[temp_limit_pkg::FLOOR_BIT] = floorFlag_q; // see R10
                readData_d[temp_limit_pkg::CEILING_BIT] = ceilingFlag_q; // see R11
            end
            temp_limit_pkg::ADDR_BUS_ERROR_STATUS: begin
                readData_d[temp_limit_pkg::PACKET_CHECK_BIT] = packetCheckFailFlag_q; // see R12
                readData_d[temp_limit_pkg::WRITE_PARITY_BIT] = writeParityFailFlag_q; // see R13
            end
            default: begin
                readData_d = 8'h00;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            regRsp.valid <= 1'b0;
            regRsp.rdata <= temp_limit_pkg::RST_STATUS;
        end else begin
            regRsp.valid <= regReq.read;
            regRsp.rdata <= regReq.read ? readData_d : regRsp.rdata;
        end
    end

endmodule

// file: test/host_model.sv
// Partner: host-side register master on the bank's strobe port
`timescale 1ns/1ps
module host_model (
    // Clock
    input wire logic mclk,
    // Register port
    output temp_limit_pkg::reg_req_t regReq,
    input wire temp_limit_pkg::reg_rsp_t regRsp
);
    // Idle lines are inverted so a stale address or data never passes for a live one
    initial regReq = '{addr: 8'h5a, write: 1'b0, read: 1'b0, wdata: 8'ha5};
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk) regReq = '{addr: a, write: 1'b1, read: 1'b0, wdata: d};
        @(negedge mclk) regReq = '{addr: ~a, write: 1'b0, read: 1'b0, wdata: ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
        @(negedge mclk) regReq = '{addr: a, write: 1'b0, read: 1'b1, wdata: ~regReq.wdata};
        @(negedge mclk) regReq = '{addr: ~a, write: 1'b0, read: 1'b0, wdata: ~regReq.wdata};
        ok = (regRsp.valid === 1'b1);
        d = regRsp.rdata;
    endtask
endmodule

// file: test/temp_limit_properties.sv
// Checker: port properties of the limit and status bank
`timescale 1ns/1ps
module temp_limit_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Register port
    input wire temp_limit_pkg::reg_req_t regReq,
    input wire temp_limit_pkg::reg_rsp_t regRsp,
    // Mode, conversion, thresholds and events
    input wire logic i3cMode,
    input wire logic pecEnable,
    input wire logic convDone,
    input wire logic [15:0] convResult,
    input wire temp_limit_pkg::thresholds_t thresholds,
    input wire logic [15:0] critLowThresh,
    input wire logic inbandIrqPending,
    input wire logic packetCheckFail,
    input wire logic writeParityFail,
    input wire logic errorClear,
    input wire logic [3:0] compareFlags
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    logic [15:0] seen_q;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) seen_q <= 16'h0000;
        else if (convDone) seen_q <= convResult;
    end
    // A read in the conversion cycle is left out: old or new reading are both fair
    sequence rdAt(a); regReq.read && regReq.addr == a && !convDone; endsequence
    sequence wrFloor; regReq.write && regReq.addr == 8'h23 ##1 !regReq.write; endsequence
    a_read_answer: assert property (regReq.read |=> regRsp.valid)
        else $error("read not answered");
    a_reading_low: assert property (rdAt(8'h31) |=> regRsp.rdata == seen_q[7:0])
        else $error("low byte wrong");
    a_reading_high: assert property (rdAt(8'h32) |=> regRsp.rdata == seen_q[15:8])
        else $error("high byte wrong");
    a_irq_status: assert property (rdAt(8'h30) |=>
        regRsp.rdata == {$past(i3cMode) && $past(inbandIrqPending), 7'h00}) else $error("irq");
    a_parity_sticky: assert property (i3cMode && writeParityFail ##1 !errorClear ##1
        rdAt(8'h34) |=>
        regRsp.rdata[0]) else $error("parity flag lost");
    a_floor_mask: assert property (wrFloor |=>
        critLowThresh[15:8] == ($past(regReq.wdata, 2) & 8'h1f)) else $error("floor mask");
    a_ceiling_flag: assert property (convDone |-> ##2
        compareFlags[0] == ($signed($past(convResult, 2)) > $signed($past(thresholds.high, 2))))
        else $error("ceiling flag");
    a_crit_floor: assert property (convDone |-> ##2
        compareFlags[3] == ($signed($past(convResult, 2)) < $signed($past(critLowThresh, 1))))
        else $error("critical floor flag");
endmodule
bind temp_limit_status_regs temp_limit_checker chk (.*);

// file: test/temp_limit_status_regs_tb.sv
// Testbench: random and corner stimulus for the limit and status bank
`timescale 1ns/1ps
module temp_limit_status_regs_tb;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    temp_limit_pkg::reg_req_t regReq;
    temp_limit_pkg::reg_rsp_t regRsp;
    logic i3cMode = 1'b0;
    logic pecEnable = 1'b0;
    logic convDone = 1'b0;
    logic [15:0] convResult = 16'h0000;
    temp_limit_pkg::thresholds_t thresholds = '0;
    logic [15:0] critLowThresh;
    logic inbandIrqPending = 1'b0;
    logic packetCheckFail = 1'b0;
    logic writeParityFail = 1'b0;
    logic errorClear = 1'b0;
    logic [3:0] compareFlags;
    logic [7:0] rv;
    logic [7:0] flr;
    logic [7:0] addrs [7] = '{8'h23, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h40};
    bit ok;
    int seed = 82;
    int fail_count = 0;
    int compares = 0;
    always #20 mclk = ~mclk;
    host_model host (.*);
    temp_limit_status_regs dut (.*);
    task automatic end_sim();
        if (fail_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, rv, ok);
        if (!ok) begin
            fail_count++;
            end_sim();
        end else check(rv, exp);
    endtask
    // Strict signed compare: a reading equal to a limit raises nothing
    function automatic logic [7:0] expFlags(input logic [15:0] t, input logic [15:0] cl);
        return {4'h0, $signed(t) < $signed(cl), $signed(t) > $signed(thresholds.critHigh),
            $signed(t) < $signed(thresholds.low), $signed(t) > $signed(thresholds.high)};
    endfunction
    initial begin
        repeat (20) @(posedge mclk);
        @(negedge mclk) reset = 1'b0;
        foreach (addrs[i]) rchk(addrs[i], 8'h00);
        host.wr(8'h23, 8'hff);
        rchk(8'h23, 8'h1f);
        host.wr(8'h31, 8'h77);
        rchk(8'h31, 8'h00);
        for (int i = 0; i < 24; i++) begin
            flr = 8'($random(seed)) & 8'h1f;
            host.wr(8'h23, flr);
            thresholds.critLowLo = 8'($random(seed));
            thresholds.low = {flr + 8'h01, 8'($random(seed))};
            thresholds.high = thresholds.low + 16'h0400;
            thresholds.critHigh = thresholds.high + 16'h0200;
            convResult = (i == 0) ? thresholds.high : 16'($random(seed));
            if (i == 1) convResult = {flr, thresholds.critLowLo};
            @(negedge mclk) convDone = 1'b1;
            @(negedge mclk) convDone = 1'b0;
            rchk(8'h31, convResult[7:0]);
            rchk(8'h32, convResult[15:8]);
            rchk(8'h33, expFlags(convResult, {flr, thresholds.critLowLo}));
            check({4'h0, compareFlags},
                expFlags(convResult, {flr, thresholds.critLowLo}));
            check(critLowThresh[15:8], flr);
            check(critLowThresh[7:0], thresholds.critLowLo);
        end
        inbandIrqPending = 1'b1;
        @(negedge mclk) packetCheckFail = 1'b1;
        writeParityFail = 1'b1;
        @(negedge mclk) packetCheckFail = 1'b0;
        writeParityFail = 1'b0;
        rchk(8'h34, 8'h00);
        rchk(8'h30, 8'h00);
        pecEnable = 1'b1;
        i3cMode = 1'b1;
        inbandIrqPending = 1'b1;
        @(negedge mclk) packetCheckFail = 1'b1;
        writeParityFail = 1'b1;
        @(negedge mclk) packetCheckFail = 1'b0;
        writeParityFail = 1'b0;
        rchk(8'h34, 8'h03);
        rchk(8'h30, 8'h80);
        @(negedge mclk) errorClear = 1'b1;
        @(negedge mclk) errorClear = 1'b0;
        rchk(8'h34, 8'h00);
        @(negedge mclk) packetCheckFail = 1'b1;
        errorClear = 1'b1;
        @(negedge mclk) packetCheckFail = 1'b0;
        errorClear = 1'b0;
        rchk(8'h34, 8'h02);
        end_sim();
    end
endmodule
